// ===== core/idau_top.sv
// Purpose: indirect addressing pointers, port decode and result flags
// Assumes: data memory answers a read combinationally in the cycle of mem_en
// Notes: one core access at a time; APB gives software a view of the state
//
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/100ps
module idau_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic acc_valid,
    output logic acc_ready,
    input wire logic [11:0] acc_addr,
    input wire logic acc_write,
    input wire logic [7:0] acc_wdata,
    input wire logic [7:0] working_register,
    output logic acc_done,
    output logic [7:0] acc_rdata,
    input wire logic flag_valid,
    input wire idau_pkg::idau_op_t flag_op,
    input wire logic [7:0] alu_a,
    input wire logic [7:0] alu_b,
    output logic [4:0] flags,
    output logic mem_en,
    output logic mem_we,
    output logic [11:0] mem_addr,
    output logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata
);
    import idau_pkg::*;

    typedef struct packed {
        logic [NPTR-1:0][11:0] ptr; // RL1
        logic [4:0] flags;
        logic en;
        idau_st_t st;
        logic men;
        logic mwe;
        logic [11:0] maddr;
        logic [7:0] mwdata;
        logic fromreg;
        logic [7:0] lrdata;
        logic [7:0] rdata;
        logic done;
        logic [31:0] prdata;
        logic pslverr;
    } idau_state_t;

    idau_state_t s_r;
    idau_state_t s_nxt;

    // ----------------------------------------
    // request decode
    // ----------------------------------------
    logic take;
    logic hit;
    logic [1:0] sel;
    idau_mode_t mode;
    logic [11:0] cur_ptr;
    logic [11:0] eff;
    logic [11:0] ptr_next;
    logic steps;
    logic t_port;
    logic t_ptr;
    logic t_flag;
    logic t_mem;
    logic [1:0] tsel;
    logic pmod;
    logic zset;
    logic apb_wr;
    logic [4:0] fval;
    logic [4:0] fmask;

    function automatic logic in_ports(input logic [11:0] a);
        in_ports = (a >= PORT_BASE) && (a <= PORT_LAST);
    endfunction

    assign take = acc_valid && acc_ready;
    assign hit = in_ports(acc_addr) && (acc_addr[2:0] < NSLOT); // RL2
    assign sel = hit ? acc_addr[4:3] : 2'h0;
    assign mode = hit ? idau_mode_t'(acc_addr[2:0]) : MD_PLAIN;
    assign cur_ptr = s_r.ptr[sel];
    assign tsel = eff[4:3];
    assign t_port = in_ports(eff) && (eff[2:0] < NSLOT);
    assign t_ptr = in_ports(eff) && ((eff[2:0] == LOW_SLOT) || (eff[2:0] == HIGH_SLOT)) && (tsel != NO_PTR);
    assign t_flag = (eff == FLAG_ADDR);
    assign t_mem = !t_port && !t_ptr && !t_flag;
    assign pmod = hit && steps && !(acc_write && t_ptr); // RL12
    assign apb_wr = psel && penable && pwrite;

    logic [11:0] calc_addr;
    idau_ptr_calc u_calc (
        .ptr(cur_ptr),
        .mode(mode),
        .working_register(working_register),
        .addr(calc_addr),
        .ptr_nxt(ptr_next),
        .steps(steps)
    );
    assign eff = hit ? calc_addr : acc_addr;

    idau_flag_alu u_alu (
        .op(flag_op),
        .a(alu_a),
        .b(alu_b),
        .cin(s_r.flags[FB_C]),
        .fval(fval),
        .fmask(fmask)
    );

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb
    begin
        s_nxt = s_r;
        zset = 1'b0;
        if (apb_wr)
        begin
            case (paddr)
                A_PTR0: s_nxt.ptr[0] = pwdata[11:0];
                A_PTR1: s_nxt.ptr[1] = pwdata[11:0];
                A_PTR2: s_nxt.ptr[2] = pwdata[11:0];
                A_FLAGS: s_nxt.flags = pwdata[4:0];
                A_CTRL: s_nxt.en = pwdata[CB_EN];
                default: s_nxt.en = s_r.en;
            endcase
        end
        if (psel && !penable)
        begin
            s_nxt.prdata = 32'h0000_0000;
            s_nxt.pslverr = 1'b0;
            case (paddr)
                A_PTR0: s_nxt.prdata[11:0] = s_r.ptr[0];
                A_PTR1: s_nxt.prdata[11:0] = s_r.ptr[1];
                A_PTR2: s_nxt.prdata[11:0] = s_r.ptr[2];
                A_FLAGS: s_nxt.prdata[4:0] = s_r.flags;
                A_CTRL:
                begin
                    s_nxt.prdata[CB_EN] = s_r.en;
                    s_nxt.prdata[CB_BUSY] = (s_r.st != ST_IDLE);
                end
                default: s_nxt.pslverr = 1'b1;
            endcase
        end
        case (s_r.st)
            ST_IDLE:
            begin
                if (take)
                begin
                    s_nxt.st = ST_ACC;
                    s_nxt.fromreg = 1'b1;
                    s_nxt.lrdata = 8'h00;
                    s_nxt.maddr = eff; // RL3
                    if (pmod)
                        s_nxt.ptr[sel] = ptr_next; // RL4 RL5 RL6 RL8 RL9
                    if (acc_write)
                    begin
                        if (t_port)
                            s_nxt.fromreg = 1'b1; // RL11
                        else if (t_ptr)
                        begin
                            if (eff[2:0] == LOW_SLOT)
                                s_nxt.ptr[tsel][7:0] = acc_wdata; // RL12
                            else
                                s_nxt.ptr[tsel][11:8] = acc_wdata[3:0]; // RL12
                        end
                        else if (t_flag)
                            s_nxt.flags = acc_wdata[4:0];
                        else
                        begin
                            s_nxt.men = 1'b1;
                            s_nxt.mwe = 1'b1;
                            s_nxt.mwdata = acc_wdata;
                            s_nxt.fromreg = 1'b0;
                        end
                    end
                    else
                    begin
                        if (t_port)
                            zset = 1'b1; // RL10
                        else if (t_ptr)
                            s_nxt.lrdata = (eff[2:0] == LOW_SLOT) ? s_r.ptr[tsel][7:0] : {4'h0, s_r.ptr[tsel][11:8]};
                        else if (t_flag)
                            s_nxt.lrdata = {3'b000, s_r.flags}; // RL14
                        else
                        begin
                            s_nxt.men = 1'b1;
                            s_nxt.fromreg = 1'b0;
                        end
                    end
                end
            end
            ST_ACC:
            begin
                s_nxt.rdata = s_r.fromreg ? s_r.lrdata : mem_rdata;
                s_nxt.done = 1'b1;
                s_nxt.men = 1'b0;
                s_nxt.mwe = 1'b0;
                s_nxt.st = ST_FIN;
            end
            ST_FIN:
            begin
                s_nxt.done = 1'b0;
                s_nxt.st = ST_IDLE;
            end
            default: s_nxt.st = ST_IDLE;
        endcase
        // computed flags win over written data
        if (flag_valid)
            s_nxt.flags = (s_nxt.flags & ~fmask) | (fval & fmask); // RL13
        if (zset && !(flag_valid && fmask[FB_Z]))
            s_nxt.flags[FB_Z] = 1'b1; // RL10
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_r <= '0;
            s_r.ptr <= {NPTR{PTR_RST}};
            s_r.flags <= FLAG_RST;
            s_r.en <= EN_RST;
            s_r.st <= ST_IDLE;
        end
        else
            s_r <= s_nxt;
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign acc_ready = (s_r.st == ST_IDLE) && s_r.en;
    assign acc_done = s_r.done;
    assign acc_rdata = s_r.rdata;
    assign flags = s_r.flags;
    assign mem_en = s_r.men;
    assign mem_we = s_r.mwe;
    assign mem_addr = s_r.maddr;
    assign mem_wdata = s_r.mwdata;
    assign prdata = s_r.prdata;
    assign pslverr = s_r.pslverr && penable;
    assign pready = penable;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic quiet;
    logic [11:0] idx_addr;
    assign quiet = !apb_wr;
    assign idx_addr = cur_ptr + {{4{working_register[7]}}, working_register};

    property p_plain;
        take && hit && (mode == MD_PLAIN) && t_mem && quiet
            |=> (s_r.ptr[$past(sel)] == $past(cur_ptr)) && mem_en && (mem_addr == $past(cur_ptr));
    endproperty
    a_plain: assert property (p_plain) else $error("plain port moved pointer or address"); // RL3

    property p_postdec;
        take && hit && (mode == MD_POSTDEC) && t_mem && quiet
            |=> (s_r.ptr[$past(sel)] == $past(cur_ptr) - 12'h001) && (mem_addr == $past(cur_ptr));
    endproperty
    a_postdec: assert property (p_postdec) else $error("post-decrement wrong"); // RL4

    property p_postinc;
        take && hit && (mode == MD_POSTINC) && t_mem && quiet
            |=> (s_r.ptr[$past(sel)] == $past(cur_ptr) + 12'h001) && (mem_addr == $past(cur_ptr));
    endproperty
    a_postinc: assert property (p_postinc) else $error("post-increment wrong"); // RL5

    property p_preinc;
        take && hit && (mode == MD_PREINC) && t_mem && quiet
            |=> (mem_addr == $past(cur_ptr) + 12'h001) && (s_r.ptr[$past(sel)] == mem_addr);
    endproperty
    a_preinc: assert property (p_preinc) else $error("pre-increment wrong"); // RL6

    property p_index;
        take && hit && (mode == MD_INDEX) && t_mem && quiet
            |=> (mem_addr == $past(idx_addr)) && (s_r.ptr[$past(sel)] == $past(cur_ptr));
    endproperty
    a_index: assert property (p_index) else $error("indexed address wrong"); // RL7

    property p_port_rd;
        take && !acc_write && t_port && quiet && !flag_valid
            |=> s_r.flags[FB_Z] ##1 (acc_done && (acc_rdata == 8'h00));
    endproperty
    a_port_rd: assert property (p_port_rd) else $error("port read not zero"); // RL10

    property p_port_wr;
        take && acc_write && t_port && quiet && !flag_valid
            |=> !mem_en && (s_r.flags == $past(s_r.flags)) ##1 !mem_we;
    endproperty
    a_port_wr: assert property (p_port_wr) else $error("port write not a no-op"); // RL11

    property p_ptr_wr;
        take && acc_write && t_ptr && hit && quiet && (eff[2:0] == LOW_SLOT)
            |=> (s_r.ptr[$past(tsel)][7:0] == $past(acc_wdata))
                && (($past(tsel) == $past(sel)) || (s_r.ptr[$past(sel)] == $past(cur_ptr)));
    endproperty
    a_ptr_wr: assert property (p_ptr_wr) else $error("pointer byte write stepped"); // RL12

    property p_noflag;
        take && pmod && t_mem && !flag_valid && quiet |=> s_r.flags == $past(s_r.flags);
    endproperty
    a_noflag: assert property (p_noflag) else $error("stepping changed flags"); // RL9

    property p_flag_rd;
        take && !acc_write && t_flag |-> ##2 acc_done && (acc_rdata[7:5] == 3'b000);
    endproperty
    a_flag_rd: assert property (p_flag_rd) else $error("flag upper bits not zero"); // RL14

    property p_flag_dest;
        take && acc_write && t_flag && flag_valid && quiet
            |=> (s_r.flags & $past(fmask)) == ($past(fval) & $past(fmask));
    endproperty
    a_flag_dest: assert property (p_flag_dest) else $error("written data reached flags"); // RL13

    c_postinc: cover property (take && hit && (mode == MD_POSTINC) ##2 acc_done);
    c_wrap: cover property (take && pmod && (cur_ptr == 12'hfff) && (mode == MD_PREINC));
    c_port_rd: cover property (take && !acc_write && t_port ##2 acc_done);
    c_flag_dest: cover property (take && acc_write && t_flag && flag_valid);
endmodule

// ===== core/idau_pkg.sv
// Purpose: constants and types of the indirect data addressing unit
// Assumes: one core clock, 12-bit data address space
// Notes: port and register addresses below are local to this unit
// Contract
// [RL1] three 12-bit pointers, each a high and a low byte
// [RL2] each pointer has a plain port plus four modifying ports
// [RL3] plain port accesses the pointed location, pointer unchanged
// [RL4] post-decrement port uses pointer, then subtracts one
// [RL5] post-increment port uses pointer, then adds one
// [RL6] pre-increment port adds one first, then uses new value
// [RL7] indexed port adds signed working register; nothing is modified
// [RL8] increment and decrement act on all 12 bits
// [RL9] pointer stepping never touches a result flag
// [RL10] indirect read of a port returns 00h and sets zero flag
// [RL11] indirect write to a port is a no-operation
// [RL12] indirect write to a pointer byte stores it, no stepping
// [RL13] flag-affecting instruction overrides written flag bits
// [RL14] flag bits 7-5 read zero, bit 4 is result sign
// [RL15] bit 3 set on signed overflow of 7-bit magnitude
// [RL16] bit 2 set when result is zero
// [RL17] bit 1 is nibble carry; rotates load source bit 4 or 3
// [RL18] bit 0 is carry out; rotates load source high or low bit
// [RL19] subtract adds two's complement; carries act as inverted borrows
// [RL20] pointer arithmetic wraps modulo 4096 with no flag
package idau_pkg;
    localparam int NPTR = 3;
    localparam logic [11:0] PORT_BASE = 12'hfe0;
    localparam logic [11:0] PORT_LAST = 12'hff7;
    localparam logic [11:0] FLAG_ADDR = 12'hfd8;
    localparam logic [2:0] NSLOT = 3'h5;
    localparam logic [2:0] LOW_SLOT = 3'h5;
    localparam logic [2:0] HIGH_SLOT = 3'h6;
    localparam logic [1:0] NO_PTR = 2'h3;
    localparam int FB_C = 0;
    localparam int FB_DC = 1;
    localparam int FB_Z = 2;
    localparam int FB_OV = 3;
    localparam int FB_N = 4;
    localparam logic [4:0] FLAG_RST = 5'h00;
    localparam logic [11:0] PTR_RST = 12'h000;
    localparam logic EN_RST = 1'b1;
    localparam logic [11:0] A_PTR0 = 12'h000;
    localparam logic [11:0] A_PTR1 = 12'h004;
    localparam logic [11:0] A_PTR2 = 12'h008;
    localparam logic [11:0] A_FLAGS = 12'h00c;
    localparam logic [11:0] A_CTRL = 12'h010;
    localparam int CB_EN = 0;
    localparam int CB_BUSY = 1;
    typedef enum logic [2:0] {MD_PLAIN = 3'h0, MD_POSTDEC = 3'h1, MD_POSTINC = 3'h2,
        MD_PREINC = 3'h3, MD_INDEX = 3'h4} idau_mode_t;
    typedef enum logic [2:0] {OP_ADD = 3'h0, OP_SUB = 3'h1, OP_AND = 3'h2, OP_IOR = 3'h3,
        OP_XOR = 3'h4, OP_RLC = 3'h5, OP_RRC = 3'h6} idau_op_t;
    typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_ACC = 2'b01, ST_FIN = 2'b11} idau_st_t;
endpackage

// ===== core/idau_ptr_calc.sv
// Purpose: access address and next pointer value for one port access
// Assumes: mode only meaningful when the port is hit
// Notes: purely combinational
`timescale 1ns/100ps
module idau_ptr_calc (
    input wire logic [11:0] ptr,
    input wire idau_pkg::idau_mode_t mode,
    input wire logic [7:0] working_register,
    output logic [11:0] addr,
    output logic [11:0] ptr_nxt,
    output logic steps
);
    import idau_pkg::*;
    logic [11:0] inc;
    logic [11:0] dec;
    logic [11:0] idx;
    assign inc = ptr + 12'h001; // RL8 RL20
    assign dec = ptr - 12'h001; // RL8 RL20
    assign idx = ptr + {{4{working_register[7]}}, working_register}; // RL7 RL20
    always_comb
    begin
        addr = ptr;
        ptr_nxt = ptr;
        steps = 1'b0;
        case (mode)
            MD_PLAIN: addr = ptr; // RL3
            MD_POSTDEC:
            begin
                ptr_nxt = dec; // RL4
                steps = 1'b1;
            end
            MD_POSTINC:
            begin
                ptr_nxt = inc; // RL5
                steps = 1'b1;
            end
            MD_PREINC:
            begin
                addr = inc; // RL6
                ptr_nxt = inc;
                steps = 1'b1;
            end
            MD_INDEX: addr = idx; // RL7
            default: addr = ptr;
        endcase
    end
endmodule

// ===== core/idau_flag_alu.sv
// Purpose: computes result flags of one arithmetic, logic or rotate step
// Assumes: operands come from the core datapath in the same cycle
// Notes: fmask marks which flags the operation affects
`timescale 1ns/100ps
module idau_flag_alu (
    input wire idau_pkg::idau_op_t op,
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    input wire logic cin,
    output logic [4:0] fval,
    output logic [4:0] fmask
);
    import idau_pkg::*;
    logic [7:0] bb;
    logic [8:0] sum;
    logic [4:0] nib;
    logic [7:0] res;
    assign bb = (op == OP_SUB) ? ~b : b; // RL19
    assign sum = {1'b0, a} + {1'b0, bb} + {8'h00, (op == OP_SUB)}; // RL19
    assign nib = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, (op == OP_SUB)};
    always_comb
    begin
        res = sum[7:0];
        fval = 5'h00;
        fmask = 5'h00;
        fmask[FB_N] = 1'b1;
        fmask[FB_Z] = 1'b1;
        case (op)
            OP_ADD, OP_SUB:
            begin
                fmask = 5'h1f;
                fval[FB_DC] = nib[4]; // RL17
                fval[FB_C] = sum[8]; // RL18
                fval[FB_OV] = (a[7] == bb[7]) && (sum[7] != a[7]); // RL15
            end
            OP_AND: res = a & b;
            OP_IOR: res = a | b;
            OP_XOR: res = a ^ b;
            OP_RLC:
            begin
                res = {a[6:0], cin};
                fmask[FB_C] = 1'b1;
                fmask[FB_DC] = 1'b1;
                fval[FB_C] = a[7]; // RL18
                fval[FB_DC] = a[3]; // RL17
            end
            OP_RRC:
            begin
                res = {cin, a[7:1]};
                fmask[FB_C] = 1'b1;
                fmask[FB_DC] = 1'b1;
                fval[FB_C] = a[0]; // RL18
                fval[FB_DC] = a[4]; // RL17
            end
            default: res = sum[7:0];
        endcase
        fval[FB_N] = res[7]; // RL14
        fval[FB_Z] = (res == 8'h00); // RL16
    end
endmodule

// ===== test/idau_mem_model.sv
// Purpose: behavioural data memory on the far side of the addressing unit
// Assumes: read data is valid combinationally while mem_en is high
// Notes: idle read data shows the inverse of the last word read
`timescale 1ns/100ps
module idau_mem_model (
    input wire logic pclk,
    input wire logic mem_en,
    input wire logic mem_we,
    input wire logic [11:0] mem_addr,
    input wire logic [7:0] mem_wdata,
    output logic [7:0] mem_rdata
);
    logic [7:0] mem_r [0:4095];
    logic [7:0] last_r;

    initial
    begin
        for (int i = 0; i < 4096; i++)
            mem_r[i] = 8'(i) ^ 8'h5a;
        last_r = 8'h00;
    end

    // no stale data outside an enabled cycle
    assign mem_rdata = mem_en ? mem_r[mem_addr] : ~last_r;

    always @(posedge pclk)
    begin
        if (mem_en)
        begin
            last_r <= mem_r[mem_addr];
            if (mem_we)
                mem_r[mem_addr] <= mem_wdata;
        end
    end
endmodule

// ===== test/tb_indirect_data_addressing.sv
// Purpose: self-checking bench of the indirect addressing unit
// Assumes: apb and core requests driven right after rising edges
// Notes: memory shadow and flag model live in the bench
`timescale 1ns/100ps
module tb_indirect_data_addressing;
    import idau_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, acc_valid, acc_write, flag_valid;
    logic pready, pslverr, acc_ready, acc_done, mem_en, mem_we, er, mwe;
    logic [11:0] paddr, acc_addr, mem_addr, men_addr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] acc_wdata, working_register, acc_rdata, alu_a, alu_b, mem_wdata, mem_rdata, ad, mwd;
    logic [4:0] flags, fexp;
    logic [4:0] fh [0:31];
    idau_op_t flag_op;
    logic [7:0] shadow [0:4095];
    int err_total = 0, tests_run = 0, cyc = 0, nen;

    idau_top i_idau_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .acc_valid(acc_valid), .acc_ready(acc_ready), .acc_addr(acc_addr), .acc_write(acc_write),
        .acc_wdata(acc_wdata), .working_register(working_register), .acc_done(acc_done), .acc_rdata(acc_rdata),
        .flag_valid(flag_valid), .flag_op(flag_op), .alu_a(alu_a), .alu_b(alu_b), .flags(flags),
        .mem_en(mem_en), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
    idau_mem_model i_idau_mem_model (.pclk(pclk), .mem_en(mem_en), .mem_we(mem_we), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

    initial pclk = 1'b0;
    always #5 pclk = ~pclk;

    // --------------------------------
    // checking and closing
    // --------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic results;
        $display("tests_run=%0d err_total=%0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            results();
        end
    end

    // --------------------------------
    // expectation helpers
    // --------------------------------
    function automatic logic [23:0] pcalc(logic [11:0] p, int m, logic [7:0] w);
        case (m)
            1: return {p, p - 12'h1};
            2: return {p, p + 12'h1};
            3: return {p + 12'h1, p + 12'h1};
            4: return {p + {{4{w[7]}}, w}, p};
            default: return {p, p};
        endcase
    endfunction

    function automatic logic [4:0] fcalc(idau_op_t op, logic [7:0] a, logic [7:0] b, logic [4:0] f);
        logic [8:0] s;
        logic [4:0] h;
        logic [7:0] r, bb;
        logic k;
        k = (op == OP_SUB);
        bb = k ? ~b : b;
        s = {1'b0, a} + {1'b0, bb} + 9'(k);
        h = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + 5'(k);
        case (op)
            OP_ADD, OP_SUB: r = s[7:0];
            OP_AND: r = a & b;
            OP_IOR: r = a | b;
            OP_XOR: r = a ^ b;
            OP_RLC: r = {a[6:0], f[FB_C]};
            default: r = {f[FB_C], a[7:1]};
        endcase
        if (op == OP_ADD || k)
            f = {r[7], (a[7] == bb[7]) && (r[7] != a[7]), r == 8'h00, h[4], s[8]};
        else if (op == OP_RLC)
            f = {r[7], f[FB_OV], r == 8'h00, a[3], a[7]};
        else if (op == OP_RRC)
            f = {r[7], f[FB_OV], r == 8'h00, a[4], a[0]};
        else
            f = {r[7], f[3], r == 8'h00, f[1:0]};
        return f;
    endfunction

    // --------------------------------
    // bus drivers
    // --------------------------------
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        check("apb ready", pready, 1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic core(input logic [11:0] a, input logic w, input logic [7:0] d);
        int n;
        @(posedge pclk);
        acc_valid <= 1'b1;
        acc_addr <= a;
        acc_write <= w;
        acc_wdata <= d;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (acc_ready !== 1'b1 && n < 50);
        acc_valid <= 1'b0;
        n = 0;
        nen = 0;
        do
        begin
            @(posedge pclk);
            n++;
            if (mem_en === 1'b1)
            begin
                nen++;
                men_addr = mem_addr;
                mwe = mem_we;
                mwd = mem_wdata;
            end
        end
        while (acc_done !== 1'b1 && n < 8);
        check("done latency", n, 2);
        ad = acc_rdata;
    endtask

    task automatic ptr_acc(input int n, input int m, input logic [11:0] p, input logic [7:0] w,
        input logic wr, input logic [7:0] d);
        logic [11:0] a, nx;
        apb(1'b1, A_PTR0 + 12'(4 * n), {20'h0, p});
        working_register <= w;
        {a, nx} = pcalc(p, m, w);
        core(PORT_BASE + 12'(8 * n + m), wr, d);
        check("mem enables", nen, 1);
        check("mem address", men_addr, a);
        if (wr)
        begin
            check("mem write", {mwe, mwd}, {1'b1, d});
            shadow[a] = d;
        end
        else
            check("read data", ad, shadow[a]);
        apb(1'b0, A_PTR0 + 12'(4 * n), 32'h0);
        check("pointer", rd, {20'h0, nx});
        check("flags kept", flags, fexp);
    endtask

    // --------------------------------
    // main sequence
    // --------------------------------
    initial
    begin
        void'($urandom(32'h0236));
        {presetn, psel, penable, pwrite, acc_valid, acc_write, flag_valid} = '0;
        {paddr, pwdata, acc_addr, acc_wdata, working_register, alu_a, alu_b} = '0;
        flag_op = OP_ADD;
        fexp = 5'h00;
        for (int i = 0; i < 4096; i++)
            shadow[i] = 8'(i) ^ 8'h5a;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 3; i++)
        begin
            apb(1'b0, A_PTR0 + 12'(4 * i), 32'h0);
            check("pointer reset", rd, 32'h0);
        end
        apb(1'b0, A_FLAGS, 32'h0);
        check("flag reset", rd, 32'h0);
        apb(1'b0, A_CTRL, 32'h0);
        check("enable reset", rd[0], 1);
        apb(1'b1, A_CTRL, 32'h0);
        @(posedge pclk) check("ready off", acc_ready, 0);
        apb(1'b1, A_CTRL, 32'h1);
        apb(1'b0, 12'h020, 32'h0);
        check("unmapped read", {er, rd}, {1'b1, 32'h0});
        apb(1'b1, 12'h024, 32'hffffffff);
        check("unmapped write", er, 1);
        // carries, borrows and wraps
        ptr_acc(0, 2, 12'h0ff, 8'h00, 1'b0, 8'h00);
        ptr_acc(1, 1, 12'h100, 8'h00, 1'b1, 8'h3c);
        ptr_acc(2, 1, 12'h000, 8'h00, 1'b0, 8'h00);
        ptr_acc(0, 3, 12'hfff, 8'h00, 1'b0, 8'h00);
        ptr_acc(1, 4, 12'h005, 8'h80, 1'b1, 8'hc3);
        ptr_acc(2, 4, 12'h7f0, 8'h7f, 1'b0, 8'h00);
        for (int k = 0; k < 40; k++)
            ptr_acc(k % 3, $urandom % 5, 12'h100 | (12'($urandom) & 12'h03f), 8'($urandom), 1'($urandom), 8'($urandom));
        // pointer aimed at a port
        apb(1'b1, A_PTR0, 32'hfe8);
        core(PORT_BASE, 1'b0, 8'h00);
        fexp[FB_Z] = 1'b1;
        check("port read", {nen[0], ad, flags}, {1'b0, 8'h00, fexp});
        apb(1'b1, A_FLAGS, 32'h0a);
        fexp = 5'h0a;
        apb(1'b1, A_PTR0, 32'hfe9);
        core(PORT_BASE + 12'h2, 1'b1, 8'h55);
        check("port write", {nen[0], flags}, {1'b0, fexp});
        // pointer aimed at a pointer byte
        apb(1'b1, A_PTR1, 32'h0);
        apb(1'b1, A_PTR0, 32'hfed);
        core(PORT_BASE + 12'h2, 1'b1, 8'h3c);
        apb(1'b0, A_PTR1, 32'h0);
        check("low byte", rd, 32'h03c);
        apb(1'b1, A_PTR0, 32'hfee);
        core(PORT_BASE + 12'h1, 1'b1, 8'ha7);
        apb(1'b0, A_PTR1, 32'h0);
        check("high byte", rd, 32'h73c);
        apb(1'b0, A_PTR0, 32'h0);
        check("no stepping", rd, 32'hfee);
        // back-to-back flag operations, every op code
        for (int i = 0; i < 32; i++)
        begin
            @(posedge pclk);
            if (i >= 2)
                check("flag result", flags, fh[i - 2]);
            if (i < 30)
            begin
                alu_a <= (i < 2) ? 8'h0f : 8'($urandom);
                alu_b <= (i == 0) ? 8'h01 : (i == 1) ? alu_a : 8'($urandom);
                flag_valid <= 1'b1;
                flag_op <= idau_op_t'(i % 7);
                #1 fexp = fcalc(idau_op_t'(i % 7), alu_a, alu_b, fexp);
                fh[i] = fexp;
            end
            else
                flag_valid <= 1'b0;
        end
        // flag register as destination of a flag-setting op
        fork
            core(FLAG_ADDR, 1'b1, 8'hff);
            begin
                @(posedge pclk);
                flag_valid <= 1'b1;
                flag_op <= OP_AND;
                alu_a <= 8'h00;
                @(posedge pclk);
                flag_valid <= 1'b0;
            end
        join
        check("flag override", flags, 5'h0f);
        apb(1'b1, A_FLAGS, 32'hff);
        apb(1'b0, A_FLAGS, 32'h0);
        check("flag upper bits", rd, 32'h1f);
        core(FLAG_ADDR, 1'b0, 8'h00);
        check("flag core read", ad, 8'h1f);
        results();
    end
endmodule
